// *** secure_config_gatekeeper_pkg.sv ***
package secure_config_gatekeeper_pkg;

  // Clock and timing. The flash wake wait is a least time, so it never drops below one cycle.
  localparam int CLK_HZ = 20_000_000;
  localparam int FLASH_WAKE_US = 30;
  localparam int WAKE_CYC = (FLASH_WAKE_US * (CLK_HZ / 1_000_000) < 1) ? 1 : FLASH_WAKE_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_W = 10;
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYC - 1);
  localparam logic [WAKE_W-1:0] WAKE_ZERO = 10'h000;

  // Widths of the stream, the fused key and the fused public key hash.
  localparam int DATA_W = 32;
  localparam int KEY_W = 256;
  localparam int HASH_W = 256;

  // Header word fields: security options and compression flag.
  localparam int HDR_ENC_BIT = 0;
  localparam int HDR_AUTH_BIT = 1;
  localparam int HDR_COMP_BIT = 2;

  // Test port instruction encodings; values are plain defaults.
  localparam int IR_W = 5;
  localparam logic [IR_W-1:0] IR_IDCODE = 5'h01;
  localparam logic [IR_W-1:0] IR_STATUS = 5'h02;
  localparam logic [IR_W-1:0] IR_BYPASS = 5'h1F;

  // Cycles after reset before the synchronised fuse level is trusted.
  localparam logic [1:0] FUSE_SETTLE = 2'h3;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_WAKE  = 6'h02,
    S_LOAD  = 6'h04,
    S_CHECK = 6'h08,
    S_USER  = 6'h10,
    S_ABORT = 6'h20
  } cfg_state_t;

  typedef struct packed {
    cfg_state_t st;
    logic rst_s1, rst_s2, rst_prev;
    logic fuse_s1, fuse_s2;
    logic [1:0] settle_cnt;
    logic settled, lock;
    logic hdr_seen, enc, auth;
    logic [WAKE_W-1:0] wake_cnt;
    logic [KEY_W-1:0] dec_key;
    logic tag_seen, tag_ok, hash_seen, hash_ok, sig_seen, sig_ok;
    logic stream_ready, flash_wake, flash_read, rsa_start;
    logic cram_wr;
    logic [DATA_W-1:0] cram_data;
    logic dec_in_valid;
    logic [DATA_W-1:0] dec_in_data;
    logic user_mode, cfg_error;
    logic ir_grant, ir_refused;
    logic [IR_W-1:0] ir_active;
  } gk_state_t;

endpackage

// *** secure_config_gatekeeper.sv ***
`timescale 1ns/100ps
// How it works
// - Encrypted payload goes through the decrypt engine with the fused 256-bit key.
// - With authentication on, the carried RSA-4096 signature must verify before user mode.
// - Only the public key hash is fused; the carried key's hash is compared to it.
// - All checks passing completes loading and enters user operation.
// - A failed signature aborts configuration; user operation is never entered.
// - Encryption and authentication are chosen independently from the stream header.
// - With the lock fuse blown, only IDCODE, status query and BYPASS are accepted.
// - The lock is permanent; no reset or reconfiguration clears it.
// - The host holds the reset low; load starts on its rising edge.
module secure_config_gatekeeper
  import secure_config_gatekeeper_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic config_reset_n,
  input wire logic test_lock_fuse,
  input wire logic [KEY_W-1:0] fuse_aes_key,
  input wire logic [HASH_W-1:0] fuse_pk_hash,
  input wire logic stream_valid,
  input wire logic [DATA_W-1:0] stream_data,
  input wire logic stream_last,
  input wire logic dec_out_valid,
  input wire logic [DATA_W-1:0] dec_out_data,
  input wire logic tag_valid,
  input wire logic tag_pass,
  input wire logic pk_hash_valid,
  input wire logic [HASH_W-1:0] pk_hash,
  input wire logic sig_valid,
  input wire logic sig_pass,
  input wire logic ir_update,
  input wire logic [IR_W-1:0] ir_code,
  output logic stream_ready,
  output logic flash_wake,
  output logic flash_read,
  output logic [KEY_W-1:0] dec_key,
  output logic dec_in_valid,
  output logic [DATA_W-1:0] dec_in_data,
  output logic rsa_start,
  output logic cram_wr,
  output logic [DATA_W-1:0] cram_data,
  output logic user_mode,
  output logic cfg_error,
  output logic test_lock,
  output logic ir_grant,
  output logic ir_refused,
  output logic [IR_W-1:0] ir_active
);

  gk_state_t q, d;
  logic rise, accept, ir_allowed, chk_fail, chk_pass;

  // Decode helpers; rise and the verdict checks read registered values, accept and ir_allowed also read raw inputs.
  assign rise = q.rst_s2 && !q.rst_prev;
  assign accept = stream_valid && q.stream_ready;
  assign ir_allowed = (ir_code == IR_IDCODE) || (ir_code == IR_STATUS) || (ir_code == IR_BYPASS);
  assign chk_fail = (q.enc && q.tag_seen && !q.tag_ok) || (q.auth && q.hash_seen && !q.hash_ok) ||
                    (q.auth && q.sig_seen && !q.sig_ok);
  assign chk_pass = (!q.enc || (q.tag_seen && q.tag_ok)) &&
                    (!q.auth || (q.hash_seen && q.hash_ok && q.sig_seen && q.sig_ok));

  // Next state. Verdict seen flags are set first and, at a new load, cleared to that cycle's valid, so a set wins.
  always_comb begin
    d = q;
    d.rst_s1 = config_reset_n;
    d.rst_s2 = q.rst_s1;
    d.rst_prev = q.rst_s2;
    d.fuse_s1 = test_lock_fuse;
    d.fuse_s2 = q.fuse_s1;
    d.flash_wake = 1'b0;
    d.flash_read = 1'b0;
    d.rsa_start = 1'b0;
    d.cram_wr = 1'b0;
    d.dec_in_valid = 1'b0;
    d.ir_refused = 1'b0;

    // The lock starts set and is released only once, after the fuse level has settled.
    if (q.fuse_s2) begin
      d.lock = 1'b1;
    end else if (!q.settled && q.settle_cnt == FUSE_SETTLE) begin
      d.lock = 1'b0;
    end
    if (q.settle_cnt != FUSE_SETTLE) begin
      d.settle_cnt = q.settle_cnt + 2'h1;
    end else begin
      d.settled = 1'b1;
    end

    // Instruction filter; a refused code is replaced by BYPASS.
    if (ir_update) begin
      if (q.lock && !ir_allowed) begin
        d.ir_grant = 1'b0;
        d.ir_refused = 1'b1;
        d.ir_active = IR_BYPASS;
      end else begin
        d.ir_grant = 1'b1;
        d.ir_active = ir_code;
      end
    end

    // Decrypted words are written to configuration memory as they return.
    if (q.enc && dec_out_valid && (q.st == S_LOAD || q.st == S_CHECK)) begin
      d.cram_wr = 1'b1;
      d.cram_data = dec_out_data;
    end

    // Verdicts from the tag, hash and signature engines.
    if (tag_valid) begin
      d.tag_seen = 1'b1;
      d.tag_ok = tag_pass;
    end
    if (pk_hash_valid) begin
      d.hash_seen = 1'b1;
      d.hash_ok = (pk_hash == fuse_pk_hash);
    end
    if (sig_valid) begin
      d.sig_seen = 1'b1;
      d.sig_ok = sig_pass;
    end

    unique case (q.st)
      S_IDLE, S_USER, S_ABORT: begin
        if (rise) begin
          d.st = S_WAKE;
          d.flash_wake = 1'b1;
          d.wake_cnt = WAKE_ZERO;
        end
      end
      S_WAKE: begin
        if (q.wake_cnt == WAKE_LAST) begin
          d.st = S_LOAD;
          d.flash_read = 1'b1;
          d.stream_ready = 1'b1;
          d.hdr_seen = 1'b0;
          d.enc = 1'b0;
          d.auth = 1'b0;
          d.tag_seen = tag_valid;
          d.hash_seen = pk_hash_valid;
          d.sig_seen = sig_valid;
          d.dec_key = fuse_aes_key;
        end else begin
          d.wake_cnt = q.wake_cnt + 10'h001;
        end
      end
      S_LOAD: begin
        if (accept && !q.hdr_seen) begin
          d.hdr_seen = 1'b1;
          d.enc = stream_data[HDR_ENC_BIT];
          d.auth = stream_data[HDR_AUTH_BIT];
          if (stream_data[HDR_COMP_BIT] && (stream_data[HDR_ENC_BIT] || stream_data[HDR_AUTH_BIT])) begin
            d.st = S_ABORT;
            d.stream_ready = 1'b0;
            d.cfg_error = 1'b1;
          end
        end else if (accept) begin
          if (q.enc) begin
            d.dec_in_valid = 1'b1;
            d.dec_in_data = stream_data;
          end else begin
            d.cram_wr = 1'b1;
            d.cram_data = stream_data;
          end
        end
        if (accept && stream_last && d.st == S_LOAD) begin
          d.st = S_CHECK;
          d.stream_ready = 1'b0;
          d.rsa_start = d.auth;
        end
      end
      S_CHECK: begin
        if (chk_fail) begin
          d.st = S_ABORT;
          d.cfg_error = 1'b1;
        end else if (chk_pass) begin
          d.st = S_USER;
          d.user_mode = 1'b1;
        end
      end
    endcase

    // Holding the reset low returns the loader to idle, clears the error and drops user operation.
    if (!q.rst_s2) begin
      d.st = S_IDLE;
      d.stream_ready = 1'b0;
      d.user_mode = 1'b0;
      d.cfg_error = 1'b0;
    end
    if (d.st == S_ABORT) begin
      d.user_mode = 1'b0;
    end
  end

  // One register stage for all state; the lock resets to the safe, locked value.
  // The reset pin stages start at the pin's idle high level, so a reset never fakes a release edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= S_IDLE;
      q.lock <= 1'b1;
      q.rst_s1 <= 1'b1;
      q.rst_s2 <= 1'b1;
      q.rst_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign stream_ready = q.stream_ready;
  assign flash_wake = q.flash_wake;
  assign flash_read = q.flash_read;
  assign dec_key = q.dec_key;
  assign dec_in_valid = q.dec_in_valid;
  assign dec_in_data = q.dec_in_data;
  assign rsa_start = q.rsa_start;
  assign cram_wr = q.cram_wr;
  assign cram_data = q.cram_data;
  assign user_mode = q.user_mode;
  assign cfg_error = q.cfg_error;
  assign test_lock = q.lock;
  assign ir_grant = q.ir_grant;
  assign ir_refused = q.ir_refused;
  assign ir_active = q.ir_active;

  // Checks on the decision logic.
  property p_abort_no_user;
    @(posedge clk) disable iff (!rst_n) (q.st == S_ABORT) |-> !user_mode;
  endproperty
  a_abort_no_user: assert property (p_abort_no_user) else $error("user mode while aborted");

  property p_pass_user;
    @(posedge clk) disable iff (!rst_n) (q.st == S_CHECK && chk_pass && !chk_fail && q.rst_s2) |=> user_mode;
  endproperty
  a_pass_user: assert property (p_pass_user) else $error("passing checks did not reach user mode");

  property p_hash_mismatch;
    @(posedge clk) disable iff (!rst_n)
      (q.st == S_CHECK && q.auth && q.hash_seen && !q.hash_ok && q.rst_s2) |=> (cfg_error && !user_mode);
  endproperty
  a_hash_mismatch: assert property (p_hash_mismatch) else $error("hash mismatch not aborted");

  property p_tag_fail;
    @(posedge clk) disable iff (!rst_n)
      (q.st == S_CHECK && q.enc && q.tag_seen && !q.tag_ok && q.rst_s2) |=> (q.st == S_ABORT);
  endproperty
  a_tag_fail: assert property (p_tag_fail) else $error("tag failure not aborted");

  property p_sig_needed;
    @(posedge clk) disable iff (!rst_n) (q.st == S_CHECK && q.auth && !q.sig_seen) |=> !user_mode;
  endproperty
  a_sig_needed: assert property (p_sig_needed) else $error("user mode without signature");

  property p_refuse;
    @(posedge clk) disable iff (!rst_n)
      (ir_update && q.lock && !ir_allowed) |=> (ir_refused && !ir_grant && ir_active == IR_BYPASS);
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked instruction accepted");

  property p_lock_kept;
    @(posedge clk) disable iff (!rst_n) (q.lock && q.settled) |=> q.lock;
  endproperty
  a_lock_kept: assert property (p_lock_kept) else $error("test lock released");

  property p_start_on_rise;
    @(posedge clk) disable iff (!rst_n) (rise && q.st != S_WAKE && q.st != S_LOAD && q.st != S_CHECK) |=>
      (q.st == S_WAKE && flash_wake);
  endproperty
  a_start_on_rise: assert property (p_start_on_rise) else $error("load not started on reset release");

  property p_enc_route;
    @(posedge clk) disable iff (!rst_n) (q.st == S_LOAD && q.enc && !dec_out_valid) |=> !cram_wr;
  endproperty
  a_enc_route: assert property (p_enc_route) else $error("plain word written while encrypted");

  property p_plain_pass;
    @(posedge clk) disable iff (!rst_n) (q.st == S_CHECK && !q.enc && !q.auth && q.rst_s2) |=> user_mode;
  endproperty
  a_plain_pass: assert property (p_plain_pass) else $error("unsecured stream not accepted");

endmodule // secure_config_gatekeeper

// *** cfg_flash_model.sv ***
`timescale 1ns/100ps
// Serial flash stand-in: a fast read returns a header and two payload words.
module cfg_flash_model
  import secure_config_gatekeeper_pkg::*;
(
  input wire logic clk,
  input wire logic config_reset_n,
  input wire logic flash_read,
  input wire logic stream_ready,
  input wire logic [DATA_W-1:0] hdr,
  output logic stream_valid,
  output logic [DATA_W-1:0] stream_data,
  output logic stream_last
);
  // Least quiet time after the reset pin rises before any word is offered.
  localparam int GAP_CYC = 32 * (CLK_HZ / 1_000_000);
  logic [2:0] idx_q = 3'h4;
  int gap_q = 0;
  // The quiet time restarts whenever the reset pin is low; it also makes the device wait on a slow source.
  always @(posedge clk) begin
    if (config_reset_n !== 1'b1) begin
      gap_q <= 0;
    end else if (gap_q < GAP_CYC) begin
      gap_q <= gap_q + 1;
    end
  end
  // A word advances only on the edge that took it; a dropped ready ends the burst until the next flash_read.
  always @(posedge clk) begin
    if (flash_read === 1'b1) begin
      idx_q <= 3'h0;
    end else if (stream_valid && stream_ready === 1'b1) begin
      idx_q <= idx_q + 3'h1;
    end else if (stream_ready !== 1'b1) begin
      idx_q <= 3'h4;
    end
  end
  // A released bus shows the inverse of the last word, so a late sample cannot pass.
  always_comb begin
    stream_valid = (idx_q < 3'h3) && (gap_q == GAP_CYC);
    stream_last = stream_valid && (idx_q == 3'h2);
    stream_data = (idx_q == 3'h0) ? hdr : (32'hA5A50000 | 32'(idx_q));
    if (!stream_valid) begin
      stream_data = ~32'hA5A50002;
    end
  end
endmodule // cfg_flash_model

// *** secure_config_gatekeeper_tb.sv ***
`timescale 1ns/100ps
module secure_config_gatekeeper_tb;
  import secure_config_gatekeeper_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic config_reset_n = 1'b0;
  logic test_lock_fuse = 1'b0;
  logic sig_valid = 1'b0;
  logic sig_pass = 1'b0;
  logic tag_valid = 1'b0;
  logic tag_pass = 1'b0;
  logic pk_hash_valid = 1'b0;
  logic ir_update = 1'b0;
  logic [IR_W-1:0] ir_code = 5'h00;
  logic [KEY_W-1:0] fuse_aes_key = {8{32'h13579BDF}};
  logic [HASH_W-1:0] fuse_pk_hash = {8{32'h2468ACE0}};
  logic [HASH_W-1:0] pk_hash = 256'h0;
  logic [DATA_W-1:0] hdr = 32'h00000000;
  logic [DATA_W-1:0] stream_data, cram_data, dec_in_data;
  logic dec_out_valid = 1'b0;
  logic [DATA_W-1:0] dec_out_data = 32'h00000000;
  localparam logic [DATA_W-1:0] DEC_MASK = 32'h5A5A5A5A;
  logic [KEY_W-1:0] dec_key;
  logic [IR_W-1:0] ir_active;
  logic stream_valid, stream_last, stream_ready, flash_wake, flash_read, dec_in_valid, rsa_start, cram_wr;
  logic user_mode, cfg_error, test_lock, ir_grant, ir_refused;
  int num_errors = 0, samples_checked = 0, cyc = 0, wr_cnt = 0, dec_cnt = 0, rsa_cnt = 0;
  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;
  secure_config_gatekeeper secure_config_gatekeeper_inst (.clk, .rst_n, .config_reset_n, .test_lock_fuse,
    .fuse_aes_key, .fuse_pk_hash, .stream_valid, .stream_data, .stream_last, .dec_out_valid,
    .dec_out_data, .tag_valid, .tag_pass, .pk_hash_valid, .pk_hash, .sig_valid, .sig_pass,
    .ir_update, .ir_code, .stream_ready, .flash_wake, .flash_read, .dec_key, .dec_in_valid, .dec_in_data,
    .rsa_start, .cram_wr, .cram_data, .user_mode, .cfg_error, .test_lock, .ir_grant, .ir_refused, .ir_active);
  cfg_flash_model cfg_flash_model_inst (.clk, .config_reset_n, .flash_read, .stream_ready, .hdr, .stream_valid,
    .stream_data, .stream_last);
  // Stand-in decrypt engine: each word comes back one cycle later with a fixed mask applied.
  always @(posedge clk) begin
    dec_out_valid <= (dec_in_valid === 1'b1);
    dec_out_data <= dec_in_data ^ DEC_MASK;
  end
  // Count output pulses per run; the cycle ceiling cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cram_wr === 1'b1) wr_cnt <= wr_cnt + 1;
    if (dec_in_valid === 1'b1) dec_cnt <= dec_cnt + 1;
    if (rsa_start === 1'b1) rsa_cnt <= rsa_cnt + 1;
    if (cyc == 12000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One full load: the verdicts arrive together once the stream has ended.
  task automatic run_cfg(input logic [31:0] h, input logic sp, hm, tp, eu, input int ew, ed);
    int n, w0, d0, r0;
    @(posedge clk);
    hdr <= h;
    config_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    w0 = wr_cnt;
    d0 = dec_cnt;
    r0 = rsa_cnt;
    config_reset_n <= 1'b1;
    n = 0;
    while (flash_wake !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    check("wake_delay", 32'(n < 8), 32'h1);
    n = 0;
    while (flash_read !== 1'b1 && n < 700) begin
      @(posedge clk);
      n++;
    end
    check("wake_wait", n, WAKE_CYC);
    wait (stream_ready === 1'b1);
    wait (stream_ready === 1'b0);
    @(posedge clk);
    sig_valid <= 1'b1;
    sig_pass <= sp;
    pk_hash_valid <= 1'b1;
    pk_hash <= hm ? fuse_pk_hash : ~fuse_pk_hash;
    tag_valid <= 1'b1;
    tag_pass <= tp;
    @(posedge clk);
    sig_valid <= 1'b0;
    pk_hash_valid <= 1'b0;
    tag_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("user_mode", {31'h0, user_mode}, {31'h0, eu});
    check("cfg_error", {31'h0, cfg_error}, {31'h0, !eu});
    check("cram_writes", wr_cnt - w0, ew);
    if (ew > 0) check("cram_data", cram_data, h[0] ? (32'hA5A50002 ^ DEC_MASK) : 32'hA5A50002);
    check("rsa_starts", rsa_cnt - r0, {31'h0, h[1]});
    check("decrypt_words", dec_cnt - d0, ed);
    check("dec_key", {31'h0, dec_key === fuse_aes_key}, 32'h1);
    $display("load with header %h done", h);
  endtask
  task automatic ir_test(input logic [IR_W-1:0] c, input logic g);
    @(posedge clk);
    ir_update <= 1'b1;
    ir_code <= c;
    @(posedge clk);
    ir_update <= 1'b0;
    #1;
    check("ir_grant", {31'h0, ir_grant}, {31'h0, g});
    check("ir_refused", {31'h0, ir_refused}, {31'h0, !g});
    check("ir_active", {27'h0, ir_active}, {27'h0, g ? c : IR_BYPASS});
    $display("instruction %h done", c);
  endtask
  // The fuse is blown on the same edge a reset is applied; neither reset nor reload may unlock the port.
  task automatic lock_test();
    @(posedge clk);
    test_lock_fuse <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("test_lock", {31'h0, test_lock}, 32'h1);
    ir_test(IR_IDCODE, 1'b1);
    ir_test(IR_STATUS, 1'b1);
    ir_test(IR_BYPASS, 1'b1);
    ir_test(5'h03, 1'b0);
    run_cfg(32'h00000000, 1'b0, 1'b0, 1'b0, 1'b1, 2, 0);
    ir_test(5'h1E, 1'b0);
  endtask
  // Header bit 0 asks for decryption, bit 1 for authentication, bit 2 marks a compressed stream.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("test_lock", {31'h0, test_lock}, 32'h0);
    ir_test(5'h03, 1'b1);
    run_cfg(32'h00000000, 1'b0, 1'b0, 1'b0, 1'b1, 2, 0);
    run_cfg(32'h00000002, 1'b1, 1'b1, 1'b0, 1'b1, 2, 0);
    run_cfg(32'h00000002, 1'b0, 1'b1, 1'b0, 1'b0, 2, 0);
    run_cfg(32'h00000002, 1'b1, 1'b0, 1'b0, 1'b0, 2, 0);
    run_cfg(32'h00000001, 1'b0, 1'b0, 1'b1, 1'b1, 2, 2);
    run_cfg(32'h00000001, 1'b0, 1'b0, 1'b0, 1'b0, 2, 2);
    run_cfg(32'h00000003, 1'b1, 1'b1, 1'b0, 1'b0, 2, 2);
    run_cfg(32'h00000003, 1'b1, 1'b1, 1'b1, 1'b1, 2, 2);
    run_cfg(32'h00000005, 1'b0, 1'b0, 1'b0, 1'b0, 0, 0);
    lock_test();
    print_verdict();
  end
endmodule // secure_config_gatekeeper_tb
